/* File: verilog/sdpci_dev.sv */
// Device end: registers pins, decodes commands, moves burst data.
// Assumes the controller keeps command protocol; memory is a small model array.
`timescale 1ns/1ns
`default_nettype none
module sdpci_dev #(
  parameter bit WIDE = 1'b1,        // 1: 32-bit part, 0: 16-bit part
  parameter bit REDUCED_PAGE = 1'b0, // Reduced page-size option
  parameter int MEM_WORDS = 256     // Model storage depth
) (
  input wire logic core_clk,
  input wire logic rst,
  sdpci_if.dev pins,
  output logic [sdpci_pkg::MODE_W-1:0] modeReg,  // Stored mode opcode
  output logic [sdpci_pkg::BANKS-1:0] bankOpen,  // Open bank flags
  output logic powerDown,                        // Low power state
  output logic selfRefresh,                      // Self refresh state
  output logic rdValid,                          // Read data captured
  input wire logic rdReady,
  output logic [sdpci_pkg::DATA_W-1:0] rdData
);
  // ----------------------------------------
  // Pin registers
  // ----------------------------------------
  logic ckeS1_r, ckeS2_r;             // Async cke sync, used in low power
  logic cke_r;                        // Registered cke
  logic [3:0] cmd_r;
  logic [1:0] bank_r;
  logic [sdpci_pkg::ADDR_W-1:0] addr_r;
  logic [sdpci_pkg::LANES-1:0] mask_r;
  logic [sdpci_pkg::DATA_W-1:0] din_r;
  logic clkOn;                        // Internal clocking runs
  logic [2:0] burstCnt_r;             // Beats left
  logic burstRead_r, autoPre_r, burstEnd;
  logic [1:0] burstBank_r;            // Bank of the running burst
  assign clkOn = cke_r && !powerDown && !selfRefresh;
  // Pins sampled only on rising edge; buffers frozen in low power
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_r <= 4'h8;
      bank_r <= '0;
      addr_r <= '0;
      mask_r <= '0;
      din_r <= '0;
    end else if (!(powerDown || selfRefresh)) begin
      cmd_r <= {pins.csN, pins.rasN, pins.casN, pins.weN};
      bank_r <= pins.bank_sel;
      addr_r <= pins.addr;
      mask_r <= pins.byte_mask;
      din_r <= pins.data_bus;
    end
  end
  // Clock enable: synchronous normally, synchronised when asleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ckeS1_r <= 1'b0;
      ckeS2_r <= 1'b0;
      cke_r <= 1'b1;
    end else begin
      ckeS1_r <= pins.cke;
      ckeS2_r <= ckeS1_r;
      cke_r <= (powerDown || selfRefresh) ? ckeS2_r : pins.cke;
    end
  end
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  sdpci_pkg::sdpci_cmd_t cmd;
  // Chip select high forces inhibit, which does nothing
  always_comb begin
    if (cmd_r[3] || !clkOn) cmd = sdpci_pkg::SDPCI_INHIBIT;
    else cmd = sdpci_pkg::sdpci_cmd_t'(cmd_r);
  end
  // Column width depends on part width
  function automatic logic [9:0] colOf(input logic [sdpci_pkg::ADDR_W-1:0] a);
    colOf = WIDE ? {1'b0, a[sdpci_pkg::COL_W32-1:0]} : a[sdpci_pkg::COL_W16-1:0];
  endfunction
  // ----------------------------------------
  // Bank and mode state
  // ----------------------------------------
  logic [sdpci_pkg::EXTRA_ROW_POS:0] rowAddr_r [sdpci_pkg::BANKS];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bankOpen <= '0;
      modeReg <= sdpci_pkg::MODE_RESET;
      for (int i = 0; i < sdpci_pkg::BANKS; i++) rowAddr_r[i] <= '0;
    end else begin
      case (cmd)
        sdpci_pkg::SDPCI_ACTIVATE: begin
          bankOpen[bank_r] <= 1'b1;
          rowAddr_r[bank_r] <= {REDUCED_PAGE & addr_r[sdpci_pkg::EXTRA_ROW_POS],
                                addr_r[sdpci_pkg::ROW_W-1:0]};
        end
        sdpci_pkg::SDPCI_PRECHARGE: begin
          if (addr_r[sdpci_pkg::AUTOPRE_POS]) bankOpen <= '0;
          else bankOpen[bank_r] <= 1'b0;
        end
        sdpci_pkg::SDPCI_LMR: modeReg <= addr_r;
        default: begin
          if (burstEnd && autoPre_r) bankOpen[burstBank_r] <= 1'b0;
        end
      endcase
    end
  end
  // Low power: entered on cke low with no burst running; open banks are not checked
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      powerDown <= 1'b0;
      selfRefresh <= 1'b0;
    end else if (powerDown || selfRefresh) begin
      if (ckeS2_r) begin
        powerDown <= 1'b0;
        selfRefresh <= 1'b0;
      end
    end else if (!cke_r && burstCnt_r == '0) begin
      // Raw code, since decode is gated off by the same low enable
      if (cmd_r == sdpci_pkg::SDPCI_REFRESH) selfRefresh <= 1'b1;
      else powerDown <= 1'b1;
    end
  end
  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  logic [9:0] col_r;                   // Burst column counter
  logic [sdpci_pkg::DATA_W-1:0] mem [MEM_WORDS];
  logic [$clog2(MEM_WORDS)-1:0] memIdx;
  assign burstEnd = clkOn && burstCnt_r == 3'd1;
  assign memIdx = {burstBank_r, col_r[$clog2(MEM_WORDS)-3:0]};
  // Counter advances on every running clock; suspended otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      burstCnt_r <= '0;
      burstRead_r <= 1'b0;
      autoPre_r <= 1'b0;
      burstBank_r <= '0;
      col_r <= '0;
    end else if (cmd == sdpci_pkg::SDPCI_READ || cmd == sdpci_pkg::SDPCI_WRITE) begin
      burstCnt_r <= 3'(sdpci_pkg::BURST_LEN);
      burstRead_r <= cmd == sdpci_pkg::SDPCI_READ;
      autoPre_r <= addr_r[sdpci_pkg::AUTOPRE_POS];
      burstBank_r <= bank_r;
      col_r <= colOf(addr_r);
    end else if (cmd == sdpci_pkg::SDPCI_TERMINATE) begin
      burstCnt_r <= '0;
    end else if (clkOn && burstCnt_r != '0) begin
      burstCnt_r <= burstCnt_r - 3'd1;
      col_r <= col_r + 10'd1;
    end
  end
  // Write beats with byte lanes masked
  logic wrBeat;
  assign wrBeat = clkOn && burstCnt_r != '0 && !burstRead_r;
  always_ff @(posedge core_clk) begin
    for (int l = 0; l < sdpci_pkg::LANES; l++) begin
      if (wrBeat && !mask_r[l] && (WIDE || l < 2)) mem[memIdx][8*l +: 8] <= din_r[8*l +: 8];
    end
  end
  // Read pipe: data delayed by latency, mask delayed by its own latency
  logic [sdpci_pkg::DATA_W-1:0] rdPipe_r [sdpci_pkg::CAS_LAT];
  logic [sdpci_pkg::CAS_LAT-1:0] rdVal_r;
  logic [sdpci_pkg::LANES-1:0] maskPipe_r [sdpci_pkg::MASK_LAT];
  logic fifoReady;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdVal_r <= '0;
      for (int i = 0; i < sdpci_pkg::CAS_LAT; i++) rdPipe_r[i] <= '0;
      for (int i = 0; i < sdpci_pkg::MASK_LAT; i++) maskPipe_r[i] <= '0;
    end else if (clkOn || !cke_r) begin
      rdVal_r <= {rdVal_r[sdpci_pkg::CAS_LAT-2:0], clkOn && burstCnt_r != '0 && burstRead_r};
      rdPipe_r[0] <= mem[memIdx];
      maskPipe_r[0] <= mask_r;
      for (int i = 1; i < sdpci_pkg::CAS_LAT; i++) rdPipe_r[i] <= rdPipe_r[i-1];
      for (int i = 1; i < sdpci_pkg::MASK_LAT; i++) maskPipe_r[i] <= maskPipe_r[i-1];
    end
  end
  // Lane drivers; 16-bit part never drives upper lanes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins.devDq <= '0;
      pins.devDqOe <= '0;
    end else begin
      pins.devDq <= rdPipe_r[sdpci_pkg::CAS_LAT-1];
      for (int l = 0; l < sdpci_pkg::LANES; l++)
        pins.devDqOe[l] <= rdVal_r[sdpci_pkg::CAS_LAT-1] && !maskPipe_r[sdpci_pkg::MASK_LAT-1][l]
                           && (WIDE || l < 2);
    end
  end
  // Read data also copied to a side FIFO for observation
  sdpci_fifo #(.WIDTH(sdpci_pkg::DATA_W), .DEPTH(32)) rdFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(rdVal_r[sdpci_pkg::CAS_LAT-1]),
    .inReady(fifoReady),
    .inData(rdPipe_r[sdpci_pkg::CAS_LAT-1]),
    .outValid(rdValid),
    .outReady(rdReady),
    .outData(rdData)
  );
endmodule
`default_nettype wire

/* File: verilog/sdpci_pkg.sv */
// Shared constants for the SDRAM pin command interface, both ends.
// Assumes a single 100 MHz core clock shared by controller and device model.
// How it works
// - Device samples every pin on rising edge.
// - Each clock advances burst counter, output data.
// - Clock enable high runs, low suspends burst counter/powers down; read pipe still drains.
// - Clock enable asynchronous while powered down.
// - Input buffers disabled during power-down.
// - Chip select high masks every command.
// - Controller encodes commands on strobe levels.
// - Write mask high discards that byte lane.
// - Read mask high floats lane two clocks later.
// - Each mask bit governs one byte lane.
// - Bank select picks target bank.
// - Precharge with auto bit ignores bank select.
// - Activate captures row from address 0-12.
// - Read/write captures column from low address.
// - Address bit 10 requests auto precharge.
// - Precharge bit 10 selects all or one.
// - Load mode takes opcode from address.
// - Extra row bit only in reduced page.
// - User activates row before read/write; controller only forwards commands.
`default_nettype none
package sdpci_pkg;
  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int DATA_W = 32;        // Data bus width
  localparam int LANES = 4;          // Byte lanes
  localparam int ADDR_W = 14;        // Address incl. extra row bit
  localparam int ROW_W = 13;         // Standard row width
  localparam int COL_W32 = 9;        // Column width, 32-bit part
  localparam int COL_W16 = 10;       // Column width, 16-bit part
  localparam int AUTOPRE_POS = 10;   // Auto precharge address bit
  localparam int EXTRA_ROW_POS = 13; // Extra row bit position
  localparam int MODE_W = 14;        // Mode register width
  localparam int BANKS = 4;          // Bank count
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CAS_LAT = 2;        // Read latency in clocks
  localparam int MASK_LAT = 2;       // Read mask latency in clocks
  localparam int BURST_LEN = 4;      // Burst length
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  // ----------------------------------------
  // Commands: {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  typedef enum logic [3:0] {
    SDPCI_INHIBIT = 4'h8,
    SDPCI_LMR = 4'h0,
    SDPCI_REFRESH = 4'h1,
    SDPCI_PRECHARGE = 4'h2,
    SDPCI_ACTIVATE = 4'h3,
    SDPCI_WRITE = 4'h4,
    SDPCI_READ = 4'h5,
    SDPCI_TERMINATE = 4'h6,
    SDPCI_NOP = 4'h7
  } sdpci_cmd_t;
endpackage
`default_nettype wire

/* File: verilog/sdpci_if.sv */
// Pin bundle between memory controller and SDRAM device end.
// Assumes the testbench resolves the data bus from the two enables.
`timescale 1ns/1ns
`default_nettype none
interface sdpci_if;
  logic cke;                          // Clock enable
  logic csN, rasN, casN, weN;         // Command strobes
  logic [1:0] bank_sel;               // Bank select
  logic [sdpci_pkg::ADDR_W-1:0] addr; // Address incl. extra_row_bit
  logic [sdpci_pkg::LANES-1:0] byte_mask; // Byte masks
  logic [sdpci_pkg::DATA_W-1:0] ctlDq;    // Controller data out
  logic [sdpci_pkg::LANES-1:0] ctlDqOe;   // Controller lane enables
  logic [sdpci_pkg::DATA_W-1:0] devDq;    // Device data out
  logic [sdpci_pkg::LANES-1:0] devDqOe;   // Device lane enables
  logic [sdpci_pkg::DATA_W-1:0] data_bus; // Resolved bus level
  modport ctl (output cke, csN, rasN, casN, weN, bank_sel, addr, byte_mask, ctlDq, ctlDqOe,
               input data_bus);
  modport dev (input cke, csN, rasN, casN, weN, bank_sel, addr, byte_mask, data_bus,
               output devDq, devDqOe);
endinterface
`default_nettype wire

/* File: verilog/sdpci_fifo.sv */
// Parameterised valid/ready FIFO used on the device read-data path.
// Assumes one clock; full and empty are exact.
`timescale 1ns/1ns
`default_nettype none
module sdpci_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // Storage
  logic [AW:0] wrPtr_r, rdPtr_r;      // Extra bit tells full from empty
  logic push, pop;
  assign inReady = (wrPtr_r - rdPtr_r) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_r != rdPtr_r;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr_r[AW-1:0]];
  // Pointers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (push) wrPtr_r <= wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= rdPtr_r + 1'b1;
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge core_clk) begin
    if (push) mem[wrPtr_r[AW-1:0]] <= inData;
  end
endmodule
`default_nettype wire

/* File: verilog/sdpci_ctl.sv */
// Controller end: turns user requests into pin commands.
// Assumes the user opens a row before reading or writing it.
`timescale 1ns/1ns
`default_nettype none
module sdpci_ctl (
  input wire logic core_clk,
  input wire logic rst,
  sdpci_if.ctl pins,
  input wire logic reqValid,                      // Command request
  output logic reqReady,
  input wire logic [3:0] reqCmd,                  // sdpci_cmd_t code
  input wire logic reqCke,                        // Clock enable level
  input wire logic [1:0] reqBank,
  input wire logic [sdpci_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [sdpci_pkg::LANES-1:0] reqMask,
  input wire logic [sdpci_pkg::DATA_W-1:0] reqData,
  input wire logic reqDrive,                      // Drive write data
  output logic [sdpci_pkg::DATA_W-1:0] busData    // Sampled bus
);
  assign reqReady = 1'b1;
  // Pins registered; idle is inhibit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pins.cke <= 1'b1;
      {pins.csN, pins.rasN, pins.casN, pins.weN} <= 4'h8;
      pins.bank_sel <= '0;
      pins.addr <= '0;
      pins.byte_mask <= '0;
      pins.ctlDq <= '0;
      pins.ctlDqOe <= '0;
      busData <= '0;
    end else begin
      pins.cke <= reqCke;
      {pins.csN, pins.rasN, pins.casN, pins.weN} <= reqValid ? reqCmd : 4'h8;
      pins.bank_sel <= reqBank;
      pins.addr <= reqAddr;
      pins.byte_mask <= reqMask;
      pins.ctlDq <= reqData;
      pins.ctlDqOe <= {sdpci_pkg::LANES{reqDrive}};
      busData <= pins.data_bus;
    end
  end
endmodule
`default_nettype wire

/* File: test/sdpci_props.sv */
// Checker on the pin bundle between controller and device ends.
// Assumes one clock, async active-high reset, signals taken straight off the interface.
`timescale 1ns/1ns
`default_nettype none
module sdpci_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [sdpci_pkg::LANES-1:0] byte_mask,
  input wire logic [sdpci_pkg::LANES-1:0] ctlDqOe,
  input wire logic [sdpci_pkg::LANES-1:0] devDqOe
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic rdCmd; // Read command on the pins
  logic [7:0] sinceRead_r; // Cycles since the last read, saturating
  assign rdCmd = cke && !csN && rasN && !casN && weN;
  // Saturating age counter, so stale bursts cannot hide
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sinceRead_r <= 8'hff;
    end else if (rdCmd) begin
      sinceRead_r <= 8'h00;
    end else if (sinceRead_r != 8'hff) begin
      sinceRead_r <= sinceRead_r + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_mask_floats_lane0: assert property (byte_mask[0] [*5] |-> !devDqOe[0])
    else $error("lane 0 driven under a held read mask");
  a_mask_floats_lane3: assert property (byte_mask[3] [*5] |-> !devDqOe[3])
    else $error("lane 3 driven under a held read mask");
  a_read_drives_bus: assert property (rdCmd && byte_mask == 4'h0 |-> ##[2:8] (devDqOe == 4'hf))
    else $error("read command gave no data on the bus");
  a_burst_four_beats: assert property ($rose(devDqOe == 4'hf) |-> (devDqOe == 4'hf) [*4])
    else $error("read burst shorter than four beats");
  a_inhibit_quiet_bus: assert property (csN [*8] ##1 csN ##1 csN |-> devDqOe == 4'h0)
    else $error("device drives while deselected");
  a_cke_low_quiet: assert property (!cke [*8] |-> devDqOe == 4'h0)
    else $error("device drives while clock is disabled");
  a_no_bus_fight: assert property ((ctlDqOe & devDqOe) == 4'h0)
    else $error("both ends drive one lane");
  a_drive_after_read: assert property ($rose(|devDqOe) |-> sinceRead_r <= 8'd8)
    else $error("device drove without a recent read");
endmodule
`default_nettype wire

/* File: test/sdpci_bench.sv */
// Self-checking bench: controller and device ends face each other.
// Assumes the package constants; the bench resolves the shared data bus.
`timescale 1ns/1ns
`default_nettype none
module sdpci_bench;
  // ----------------------------------------
  // Stimulus signals
  // ----------------------------------------
  logic core_clk = 1'b0, rst = 1'b1, tick = 1'b0;
  logic reqValid = 1'b1, reqCke = 1'b1, reqDrive = 1'b0, rdReady = 1'b0;
  logic [3:0] reqCmd = 4'h8, reqMask = 4'h0;
  logic [1:0] reqBank = 2'h0;
  logic [13:0] reqAddr = 14'h0000;
  logic [31:0] reqData = 32'h00000000;
  logic reqReady, powerDown, selfRefresh, rdValid;
  logic [31:0] busData, rdData;
  logic [13:0] modeReg;
  logic [3:0] bankOpen;
  int n_fail = 0, n_compared = 0;
  localparam logic [31:0] WORD_A = 32'h11223344, WORD_B = 32'ha5b6c7d8;
  localparam logic [31:0] WORD_X = (WORD_B & 32'hffff00ff) | (WORD_A & 32'h0000ff00);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) tick <= ~tick; // Idle lanes toggle, no stale value
  sdpci_if pins();
  // Bus resolution, lane by lane; released lanes never keep old data
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      pins.data_bus[8*l+:8] = pins.devDqOe[l] ? pins.devDq[8*l+:8] :
        pins.ctlDqOe[l] ? pins.ctlDq[8*l+:8] : {4{tick, ~tick}};
    end
  end
  sdpci_ctl i_sdpci_ctl (.core_clk(core_clk), .rst(rst), .pins(pins.ctl), .reqValid(reqValid),
    .reqReady(reqReady), .reqCmd(reqCmd), .reqCke(reqCke), .reqBank(reqBank), .reqAddr(reqAddr),
    .reqMask(reqMask), .reqData(reqData), .reqDrive(reqDrive), .busData(busData));
  sdpci_dev #(.WIDE(1'b1), .REDUCED_PAGE(1'b0), .MEM_WORDS(256)) i_sdpci_dev (.core_clk(core_clk),
    .rst(rst), .pins(pins.dev), .modeReg(modeReg), .bankOpen(bankOpen), .powerDown(powerDown),
    .selfRefresh(selfRefresh), .rdValid(rdValid), .rdReady(rdReady), .rdData(rdData));
  sdpci_props i_sdpci_props (.core_clk(core_clk), .rst(rst), .cke(pins.cke), .csN(pins.csN),
    .rasN(pins.rasN), .casN(pins.casN), .weN(pins.weN), .byte_mask(pins.byte_mask),
    .ctlDqOe(pins.ctlDqOe), .devDqOe(pins.devDqOe));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One request per cycle, driven at the falling edge
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank, input logic [13:0] addr,
      input logic [3:0] mask, input logic [31:0] data, input logic drive, input logic cke);
    reqCmd = cmd;
    reqBank = bank;
    reqAddr = addr;
    reqMask = mask;
    reqData = data;
    reqDrive = drive;
    reqCke = cke;
    @(negedge core_clk);
  endtask
  task automatic idle(input int n, input logic [3:0] mask, input logic cke);
    repeat (n) issue(4'h8, 2'h0, 14'h0000, mask, 32'h0, 1'b0, cke);
  endtask
  // Four-beat write burst, same word each beat; beats take data after the command cycle
  task automatic wr(input logic [31:0] data, input logic [3:0] mask);
    issue(sdpci_pkg::SDPCI_WRITE, 2'h2, 14'h0000, mask, data, 1'b1, 1'b1);
    repeat (4) issue(sdpci_pkg::SDPCI_NOP, 2'h2, 14'h0000, mask, data, 1'b1, 1'b1);
    idle(6, 4'h0, 1'b1);
  endtask
  task automatic rd(input logic [3:0] mask);
    issue(sdpci_pkg::SDPCI_READ, 2'h2, 14'h0000, mask, 32'h0, 1'b0, 1'b1);
    idle(10, mask, 1'b1);
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait for one read beat, then accept it
  task automatic pop(input logic [31:0] exp, input logic [31:0] keep);
    int k;
    for (k = 0; k < 50 && rdValid !== 1'b1; k++) @(negedge core_clk);
    if (k == 50) begin
      n_fail++;
      $display("mismatch at %0t: read beat never came", $time);
      results();
    end else begin
      check(rdData & keep, exp & keep, "read beat");
      rdReady = 1'b1;
      @(negedge core_clk);
      rdReady = 1'b0;
    end
  endtask
  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    check(bankOpen, 4'h0, "banks after reset");
    check(modeReg, 14'h0000, "mode after reset");
    $display("done: reset");
    repeat (2) issue(4'h8, 2'h0, 14'h0000, 4'h0, 32'h5a5a0ff0, 1'b1, 1'b1);
    check(busData, 32'h5a5a0ff0, "bus loopback");
    issue(sdpci_pkg::SDPCI_LMR, 2'h0, 14'h0022, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    check(modeReg, 14'h0022, "mode opcode");
    issue(sdpci_pkg::SDPCI_ACTIVATE | 4'h8, 2'h1, 14'h0123, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    check(bankOpen, 4'h0, "deselected activate");
    issue(sdpci_pkg::SDPCI_ACTIVATE, 2'h2, 14'h1abc, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    check(bankOpen, 4'h4, "activate bank 2");
    $display("done: commands");
    wr(WORD_A, 4'h0);
    wr(WORD_B, 4'h2);
    for (int i = 0; i < 8; i++) rd(4'h0); // Fills the buffer with the consumer stalled
    for (int i = 0; i < 32; i++) pop(WORD_X, 32'hffffffff);
    @(negedge core_clk);
    check(rdValid, 1'b0, "buffer drained");
    $display("done: write mask and buffer");
    rd(4'h1);
    for (int i = 0; i < 4; i++) pop(WORD_X, 32'hffffff00);
    $display("done: read mask");
    issue(sdpci_pkg::SDPCI_ACTIVATE, 2'h0, 14'h0001, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    issue(sdpci_pkg::SDPCI_PRECHARGE, 2'h2, 14'h0000, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    check(bankOpen, 4'h1, "single bank precharge");
    issue(sdpci_pkg::SDPCI_ACTIVATE, 2'h3, 14'h0002, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    issue(sdpci_pkg::SDPCI_PRECHARGE, 2'h1, 14'h0400, 4'h0, 32'h0, 1'b0, 1'b1);
    idle(4, 4'h0, 1'b1);
    check(bankOpen, 4'h0, "all bank precharge");
    $display("done: precharge");
    idle(12, 4'h0, 1'b0);
    check(powerDown, 1'b1, "power-down entry");
    idle(8, 4'h0, 1'b1);
    check(powerDown, 1'b0, "power-down exit");
    issue(sdpci_pkg::SDPCI_REFRESH, 2'h0, 14'h0000, 4'h0, 32'h0, 1'b0, 1'b0);
    idle(10, 4'h0, 1'b0);
    check(selfRefresh, 1'b1, "self refresh entry");
    idle(8, 4'h0, 1'b1);
    check(selfRefresh, 1'b0, "self refresh exit");
    $display("done: low power");
    results();
  end
  initial begin
    #900us;
    n_fail++;
    $display("mismatch at %0t: run limit reached", $time);
    results();
  end
endmodule
`default_nettype wire
